// ===== src/adcf_flags.sv
// Operation
// RULE1: Channel 11 threshold flag sets on enabled outside or crossing event.
// RULE2: Channel 11 threshold flag clears by writing one; zero leaves it.
// RULE3: Bits 12..23 show channel 0..11 result overrun status.
// RULE4: Bit 24 shows sequence A global result overrun.
// RULE5: Bit 25 shows sequence B global result overrun.
// RULE6: Software writes only zeros to reserved bits 27:26.
// RULE7: Reserved bits 27:26 read undefined; nothing depends on them.
// RULE8: Mode 0: sequence A flag follows result valid bit.
// RULE9: Mode 0: result valid sets at every sequence A conversion end.
// RULE10: Mode 0: reading sequence A global result clears the flag.
// RULE11: Mode 1: flag sets only when a whole A pass completes.
// RULE12: Mode 1: flag holds until one written to bit 28.
// RULE13: Sequence A flag raises interrupt only when enabled.
// RULE14: Sequence A flag also serves as DMA request.
// RULE15: Threshold summary set while any of twelve threshold flags set.
// RULE16: Overrun mirror bits are read-only; writes ignored.
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.svh"

module adcf_flags (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CONV_DONE_A,
  input wire logic SEQ_A_DONE,
  input wire logic [11:0] SEQ_A_RESULT,
  input wire logic THR_OUTSIDE_CH11,
  input wire logic THR_CROSS_CH11,
  input wire logic [10:0] THR_FLAGS_LOW,
  input wire logic [11:0] CHAN_OVERRUN,
  input wire logic SEQ_A_OVERRUN,
  input wire logic SEQ_B_OVERRUN,
  output logic SEQ_A_MODE,
  output logic SEQ_A_DMA_REQ,
  output logic THRESHOLD_SUMMARY,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Address to register select, shared by read and write paths
  function automatic adcf_pkg::adcf_reg_t decode(input logic [11:0] a);
    adcf_pkg::adcf_reg_t r;
    r = adcf_pkg::REG_NONE;
    if ({a[11:2], 2'h0} == `ADCF_OFS_SEQ_A_CONTROL_REG) begin
      r = adcf_pkg::REG_SEQ_A_CONTROL_REG;
    end else if ({a[11:2], 2'h0} == `ADCF_OFS_SEQA_GRES) begin
      r = adcf_pkg::REG_SEQA_GRES;
    end else if ({a[11:2], 2'h0} == `ADCF_OFS_IRQ_EN) begin
      r = adcf_pkg::REG_IRQ_EN;
    end else if ({a[11:2], 2'h0} == `ADCF_OFS_FLAGS) begin
      r = adcf_pkg::REG_FLAGS;
    end
    return r;
  endfunction

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Declarations

  adcf_pkg::adcf_wr_state_t wst_q;
  adcf_pkg::adcf_rd_state_t rst_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic [31:0] wr_ones;
  adcf_pkg::adcf_reg_t wr_sel;
  adcf_pkg::adcf_reg_t rd_sel;
  logic rd_fire;
  logic [31:0] rd_mux;
  logic mode_q;
  logic [4:0] ien_q;
  adcf_pkg::adcf_thr_type_t thr_type;
  logic thr11_set;
  logic thr11_clr;
  logic thr11;
  logic valid_clr;
  logic res_valid;
  logic done_set;
  logic done_clr;
  logic seq_done;
  logic seqa_flag;
  logic ovr_any;
  logic [31:0] flags_view;
  logic [31:0] gres_view;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////
  // Write channel

  // Handshake readies depend only on state
  assign S_AXI_AWREADY = (wst_q == adcf_pkg::WS_IDLE) || (wst_q == adcf_pkg::WS_HAVE_W);
  assign S_AXI_WREADY = (wst_q == adcf_pkg::WS_IDLE) || (wst_q == adcf_pkg::WS_HAVE_A);
  assign S_AXI_BVALID = (wst_q == adcf_pkg::WS_RESP);
  assign S_AXI_BRESP = bresp_q;

  // Write completes when the later of address and data is taken
  always_comb begin
    wr_fire = 1'h0;
    unique case (wst_q)
      adcf_pkg::WS_IDLE: wr_fire = S_AXI_AWVALID && S_AXI_WVALID;
      adcf_pkg::WS_HAVE_A: wr_fire = S_AXI_WVALID;
      adcf_pkg::WS_HAVE_W: wr_fire = S_AXI_AWVALID;
      adcf_pkg::WS_RESP: wr_fire = 1'h0;
    endcase
  end

  assign wr_addr = (wst_q == adcf_pkg::WS_HAVE_A) ? awaddr_q : S_AXI_AWADDR;
  assign wr_data = (wst_q == adcf_pkg::WS_HAVE_W) ? wdata_q : S_AXI_WDATA;
  assign wr_mask = lane_mask((wst_q == adcf_pkg::WS_HAVE_W) ? wstrb_q : S_AXI_WSTRB);
  assign wr_sel = decode(wr_addr);
  // Ones written with enabled lanes, the W1C operand
  assign wr_ones = wr_fire ? (wr_data & wr_mask) : 32'h0;

  // Write state machine, address and data in either order
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wst_q <= adcf_pkg::WS_IDLE;
    end else begin
      unique case (wst_q)
        adcf_pkg::WS_IDLE: begin
          if (wr_fire) begin
            wst_q <= adcf_pkg::WS_RESP;
          end else if (S_AXI_AWVALID) begin
            wst_q <= adcf_pkg::WS_HAVE_A;
          end else if (S_AXI_WVALID) begin
            wst_q <= adcf_pkg::WS_HAVE_W;
          end
        end
        adcf_pkg::WS_HAVE_A, adcf_pkg::WS_HAVE_W: begin
          if (wr_fire) begin
            wst_q <= adcf_pkg::WS_RESP;
          end
        end
        adcf_pkg::WS_RESP: begin
          if (S_AXI_BREADY) begin
            wst_q <= adcf_pkg::WS_IDLE;
          end
        end
      endcase
    end
  end

  // Hold whichever half arrived first
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (wst_q == adcf_pkg::WS_IDLE) begin
      awaddr_q <= S_AXI_AWADDR;
      wdata_q <= S_AXI_WDATA;
      wstrb_q <= S_AXI_WSTRB;
    end
  end

  // Unmapped writes answer with a slave error
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      bresp_q <= `ADCF_RESP_OKAY;
    end else if (wr_fire) begin
      bresp_q <= (wr_sel == adcf_pkg::REG_NONE) ? `ADCF_RESP_SLVERR : `ADCF_RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read channel

  assign S_AXI_ARREADY = (rst_q == adcf_pkg::RS_IDLE);
  assign S_AXI_RVALID = (rst_q == adcf_pkg::RS_DATA);
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign rd_fire = S_AXI_ARVALID && (rst_q == adcf_pkg::RS_IDLE);
  assign rd_sel = decode(S_AXI_ARADDR);

  // Read data mux, sampled once into the data register
  always_comb begin
    rd_mux = 32'h0;
    unique case (rd_sel)
      adcf_pkg::REG_SEQ_A_CONTROL_REG: rd_mux[`ADCF_CTL_MODE] = mode_q;
      adcf_pkg::REG_SEQA_GRES: rd_mux = gres_view;
      adcf_pkg::REG_IRQ_EN: rd_mux[4:0] = ien_q;
      adcf_pkg::REG_FLAGS: rd_mux = flags_view;
      adcf_pkg::REG_NONE: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rst_q <= adcf_pkg::RS_IDLE;
    end else if (rd_fire) begin
      rst_q <= adcf_pkg::RS_DATA;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      rst_q <= adcf_pkg::RS_IDLE;
    end
  end

  // Data and response are frozen while rvalid stands
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rdata_q <= 32'h0;
      rresp_q <= `ADCF_RESP_OKAY;
    end else if (rd_fire) begin
      rdata_q <= rd_mux;
      rresp_q <= (rd_sel == adcf_pkg::REG_NONE) ? `ADCF_RESP_SLVERR : `ADCF_RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers

  // Mode bit of sequence A
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mode_q <= `ADCF_CTL_MODE_RST;
    end else if (wr_fire && wr_sel == adcf_pkg::REG_SEQ_A_CONTROL_REG && wr_mask[`ADCF_CTL_MODE]) begin
      mode_q <= wr_data[`ADCF_CTL_MODE];
    end
  end

  // Interrupt enables, byte lane 0 only
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ien_q <= `ADCF_IEN_RST;
    end else if (wr_fire && wr_sel == adcf_pkg::REG_IRQ_EN && wr_mask[0]) begin
      ien_q <= wr_data[4:0];
    end
  end

  assign thr_type = adcf_pkg::adcf_thr_type_t'(ien_q[`ADCF_IEN_THR_HI:`ADCF_IEN_THR_LO]);
  assign SEQ_A_MODE = mode_q;

  ////////////////////////////////////////////////////////////////////
  // Flags

  // RULE1: gated event set
  // Reserved type code is treated as disabled
  assign thr11_set = (thr_type == adcf_pkg::THR_OUTSIDE && THR_OUTSIDE_CH11)
                  || (thr_type == adcf_pkg::THR_CROSS && THR_CROSS_CH11);
  // RULE2: write-one clear
  assign thr11_clr = wr_sel == adcf_pkg::REG_FLAGS && wr_ones[`ADCF_FLG_THR11];

  adcf_sticky_bit u_thr11 (
    .clk(CLOCK),
    .srst(SRST),
    .set(thr11_set),
    .clr(thr11_clr),
    .q(thr11)
  );

  // RULE9: valid per conversion
  // RULE10: cleared by result read
  // A conversion ending with the read keeps valid set
  assign valid_clr = rd_fire && rd_sel == adcf_pkg::REG_SEQA_GRES;

  adcf_sticky_bit u_valid (
    .clk(CLOCK),
    .srst(SRST),
    .set(CONV_DONE_A),
    .clr(valid_clr),
    .q(res_valid)
  );

  // RULE11: whole pass sets
  // RULE12: write-one clear only while in mode 1
  // Leaving end-of-pass mode drops a stale flag
  assign done_set = mode_q && SEQ_A_DONE;
  assign done_clr = !mode_q
                 || (wr_sel == adcf_pkg::REG_FLAGS && wr_ones[`ADCF_FLG_SEQA_IRQ]);

  adcf_sticky_bit u_done (
    .clk(CLOCK),
    .srst(SRST),
    .set(done_set),
    .clr(done_clr),
    .q(seq_done)
  );

  // RULE8: mode 0 mirrors valid
  assign seqa_flag = mode_q ? seq_done : res_valid;

  // Global result as software sees it
  always_comb begin
    gres_view = 32'h0;
    gres_view[`ADCF_GRS_DATA_HI:`ADCF_GRS_DATA_LO] = SEQ_A_RESULT;
    gres_view[`ADCF_GRS_OVR] = SEQ_A_OVERRUN;
    gres_view[`ADCF_GRS_VALID] = res_valid;
  end

  // Flag register read view; low threshold bits live outside
  always_comb begin
    flags_view = 32'h0;
    flags_view[10:0] = THR_FLAGS_LOW;
    flags_view[`ADCF_FLG_THR11] = thr11;
    // RULE3: channel overrun mirrors
    // RULE16: no write path
    flags_view[`ADCF_FLG_CHOVR_HI:`ADCF_FLG_CHOVR_LO] = CHAN_OVERRUN;
    // RULE4: sequence A overrun
    flags_view[`ADCF_FLG_SEQ_A_OVERRUN_MIRROR] = SEQ_A_OVERRUN;
    // RULE5: sequence B overrun
    flags_view[`ADCF_FLG_SEQ_B_OVERRUN_MIRROR] = SEQ_B_OVERRUN;
    // RULE7: reserved read value
    // RULE6: writes there ignored
    flags_view[`ADCF_FLG_RSV_HI:`ADCF_FLG_RSV_LO] = `ADCF_FLG_RSV_VAL;
    flags_view[`ADCF_FLG_SEQA_IRQ] = seqa_flag;
  end

  ////////////////////////////////////////////////////////////////////
  // Requests out

  // RULE14: flag drives DMA
  assign SEQ_A_DMA_REQ = seqa_flag;

  // RULE15: summary of twelve
  assign THRESHOLD_SUMMARY = thr11 || (|THR_FLAGS_LOW);

  // Sequence A global overrun counts only in per-conversion mode
  assign ovr_any = (|CHAN_OVERRUN) || (!mode_q && SEQ_A_OVERRUN) || SEQ_B_OVERRUN;

  // RULE13: enable gates request
  // Registered so the line is glitch free; one cycle behind the flags
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= (seqa_flag && ien_q[`ADCF_IEN_SEQA])
            || (THRESHOLD_SUMMARY && ien_q[`ADCF_IEN_THR_ANY])
            || (ovr_any && ien_q[`ADCF_IEN_OVR]);
    end
  end

  assign IRQ = irq_q;

endmodule

`default_nettype wire

// ===== src/adcf_map.svh
`ifndef ADCF_MAP_SVH
`define ADCF_MAP_SVH

// Register byte offsets (12-bit window)
`define ADCF_ADDR_W 12
`define ADCF_OFS_SEQ_A_CONTROL_REG 12'h000
`define ADCF_OFS_SEQA_GRES 12'h010
`define ADCF_OFS_IRQ_EN 12'h064
`define ADCF_OFS_FLAGS 12'h068

// Flag register fields
`define ADCF_FLG_THR11 11
`define ADCF_FLG_CHOVR_LO 12
`define ADCF_FLG_CHOVR_HI 23
`define ADCF_FLG_SEQ_A_OVERRUN_MIRROR 24
`define ADCF_FLG_SEQ_B_OVERRUN_MIRROR 25
`define ADCF_FLG_RSV_LO 26
`define ADCF_FLG_RSV_HI 27
`define ADCF_FLG_SEQA_IRQ 28
`define ADCF_FLG_RSV_VAL 2'h0

// Sequence A control fields
`define ADCF_CTL_MODE 30
`define ADCF_CTL_MODE_RST 1'h0

// Interrupt enable fields
`define ADCF_IEN_SEQA 0
`define ADCF_IEN_THR_LO 1
`define ADCF_IEN_THR_HI 2
`define ADCF_IEN_OVR 3
`define ADCF_IEN_THR_ANY 4
`define ADCF_IEN_RST 5'h00

// Sequence A global result fields
`define ADCF_GRS_DATA_LO 4
`define ADCF_GRS_DATA_HI 15
`define ADCF_GRS_OVR 30
`define ADCF_GRS_VALID 31

// Bus responses
`define ADCF_RESP_OKAY 2'h0
`define ADCF_RESP_SLVERR 2'h2

`endif

// ===== src/adcf_pkg.sv
`default_nettype none

package adcf_pkg;

  // Threshold event type select for channel 11
  typedef enum logic [1:0] {
    THR_OFF = 2'h0,
    THR_OUTSIDE = 2'h1,
    THR_CROSS = 2'h2,
    THR_RSVD = 2'h3
  } adcf_thr_type_t;

  // Write channel states, Gray along idle -> addr -> resp
  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_HAVE_A = 2'h1,
    WS_RESP = 2'h3,
    WS_HAVE_W = 2'h2
  } adcf_wr_state_t;

  typedef enum logic {
    RS_IDLE = 1'h0,
    RS_DATA = 1'h1
  } adcf_rd_state_t;

  // Decoded register select
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_SEQ_A_CONTROL_REG = 3'h1,
    REG_SEQA_GRES = 3'h2,
    REG_IRQ_EN = 3'h3,
    REG_FLAGS = 3'h4
  } adcf_reg_t;

endpackage

`default_nettype wire

// ===== src/adcf_sticky_bit.sv
`timescale 1ns/1ps
`default_nettype none

module adcf_sticky_bit (
  input wire logic clk,
  input wire logic srst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_q;

  // Set beats clear so a same-cycle event is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      q_q <= 1'h0;
    end else if (set) begin
      q_q <= 1'h1;
    end else if (clr) begin
      q_q <= 1'h0;
    end
  end

  assign q = q_q;

endmodule

`default_nettype wire

// ===== verif/adcf_flags_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.svh"

module adcf_flags_chk (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic CONV_DONE_A,
  input wire logic SEQ_A_DONE,
  input wire logic [10:0] THR_FLAGS_LOW,
  input wire logic [11:0] CHAN_OVERRUN,
  input wire logic SEQ_A_OVERRUN,
  input wire logic SEQ_B_OVERRUN,
  input wire logic SEQ_A_MODE,
  input wire logic SEQ_A_DMA_REQ,
  input wire logic THRESHOLD_SUMMARY,
  input wire logic IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic wrote_q;
  // Enables reset to zero, so no request can exist before a first write
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wrote_q <= 1'h0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      wrote_q <= 1'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered next cycle");
  AST_CH_OVR_MIRROR: assert property ($rose(S_AXI_RVALID)
    && $past(S_AXI_ARADDR) == `ADCF_OFS_FLAGS |-> S_AXI_RDATA[23:12] == $past(CHAN_OVERRUN))
    else $error("channel overrun mirror wrong");
  AST_SEQ_OVR_MIRROR: assert property ($rose(S_AXI_RVALID) &&
    $past(S_AXI_ARADDR) == `ADCF_OFS_FLAGS |->
    S_AXI_RDATA[25:24] == $past({SEQ_B_OVERRUN, SEQ_A_OVERRUN}))
    else $error("sequence overrun mirror wrong");
  AST_CONV_SETS: assert property (CONV_DONE_A && !SEQ_A_MODE |=>
    SEQ_A_MODE || SEQ_A_DMA_REQ)
    else $error("conversion end did not set flag");
  AST_READ_CLEARS: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == `ADCF_OFS_SEQA_GRES && !CONV_DONE_A && !SEQ_A_MODE |=> !SEQ_A_DMA_REQ)
    else $error("result read did not clear flag");
  AST_SEQ_SETS: assert property (SEQ_A_MODE && $past(SEQ_A_MODE) &&
    $rose(SEQ_A_DMA_REQ) |-> $past(SEQ_A_DONE))
    else $error("flag set without sequence end");
  AST_SEQ_HOLDS: assert property (SEQ_A_MODE && $past(SEQ_A_MODE) &&
    $fell(SEQ_A_DMA_REQ) |-> $past(S_AXI_WVALID || S_AXI_AWVALID))
    else $error("flag cleared without write");
  AST_IRQ_GATED: assert property (!wrote_q |-> !IRQ)
    else $error("interrupt while disabled");
  // Registered request needs a live cause one cycle earlier
  AST_IRQ_CAUSE: assert property (IRQ |-> $past(SEQ_A_DMA_REQ || THRESHOLD_SUMMARY
    || (|CHAN_OVERRUN) || SEQ_A_OVERRUN || SEQ_B_OVERRUN))
    else $error("interrupt without a cause");
  AST_SUMMARY: assert property (|THR_FLAGS_LOW |-> THRESHOLD_SUMMARY)
    else $error("summary low with flag set");
  COV_CONV: cover property (CONV_DONE_A ##1 SEQ_A_DMA_REQ);
  COV_SEQ: cover property (SEQ_A_MODE && SEQ_A_DONE);
  COV_IRQ: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// ===== verif/adc_flag_register_upper_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.svh"

module adc_flag_register_upper_bits_tb;
  logic CLOCK, SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR, SEQ_A_RESULT, CHAN_OVERRUN;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic CONV_DONE_A, SEQ_A_DONE, THR_OUTSIDE_CH11, THR_CROSS_CH11, SEQ_A_OVERRUN, SEQ_B_OVERRUN;
  logic [10:0] THR_FLAGS_LOW;
  logic SEQ_A_MODE, SEQ_A_DMA_REQ, THRESHOLD_SUMMARY, IRQ, e;
  int mismatches, n_compared, cycles;

  adcf_flags dut_u (
    .CLOCK(CLOCK), .SRST(SRST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .CONV_DONE_A(CONV_DONE_A),
    .SEQ_A_DONE(SEQ_A_DONE), .SEQ_A_RESULT(SEQ_A_RESULT),
    .THR_OUTSIDE_CH11(THR_OUTSIDE_CH11), .THR_CROSS_CH11(THR_CROSS_CH11),
    .THR_FLAGS_LOW(THR_FLAGS_LOW), .CHAN_OVERRUN(CHAN_OVERRUN),
    .SEQ_A_OVERRUN(SEQ_A_OVERRUN), .SEQ_B_OVERRUN(SEQ_B_OVERRUN),
    .SEQ_A_MODE(SEQ_A_MODE), .SEQ_A_DMA_REQ(SEQ_A_DMA_REQ),
    .THRESHOLD_SUMMARY(THRESHOLD_SUMMARY), .IRQ(IRQ)
  );

  // 40 MHz clock
  initial begin
    CLOCK = 1'h0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
    #1;
  endtask

  task rd(input logic [11:0] a);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
    #1;
  endtask

  // One-cycle core event; returns once flag and interrupt have settled
  task pulse(input int k);
    @(posedge CLOCK);
    case (k)
      0: CONV_DONE_A <= 1'h1;
      1: SEQ_A_DONE <= 1'h1;
      2: THR_OUTSIDE_CH11 <= 1'h1;
      default: THR_CROSS_CH11 <= 1'h1;
    endcase
    @(posedge CLOCK);
    {CONV_DONE_A, SEQ_A_DONE, THR_OUTSIDE_CH11, THR_CROSS_CH11} <= 4'h0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rd(`ADCF_OFS_FLAGS);
    chk("rresp_ok", `ADCF_RESP_OKAY, r);
    chk("flags", 32'h0, d & 32'hf3ffffff);
    rd(`ADCF_OFS_IRQ_EN);
    chk("irq_en", 32'h0, d);
    chk("irq", 32'h0, IRQ);
  endtask

  // Every threshold type code against both event kinds
  task t_thr;
    for (int t = 0; t < 4; t++) begin
      wr(`ADCF_OFS_IRQ_EN, 32'h10 | (t << 1));
      for (int k = 2; k < 4; k++) begin
        e = (t == k - 1);
        pulse(k);
        chk("summary", e, THRESHOLD_SUMMARY);
        chk("thr_irq", e, IRQ);
        wr(`ADCF_OFS_FLAGS, 32'h0);
        rd(`ADCF_OFS_FLAGS);
        chk("thr11_kept", e, d[11]);
        wr(`ADCF_OFS_FLAGS, 32'h800);
        rd(`ADCF_OFS_FLAGS);
        chk("thr11_clr", 32'h0, d[11]);
      end
    end
    @(posedge CLOCK);
    THR_FLAGS_LOW <= 11'h400;
    rd(`ADCF_OFS_FLAGS);
    chk("summary_low", 32'h1, THRESHOLD_SUMMARY);
    chk("thr_low_view", 32'h400, d & 32'h7ff);
    @(posedge CLOCK);
    THR_FLAGS_LOW <= 11'h0;
  endtask

  task t_ovr;
    wr(`ADCF_OFS_IRQ_EN, 32'h0);
    for (int i = 0; i < 14; i++) begin
      @(posedge CLOCK);
      {SEQ_B_OVERRUN, SEQ_A_OVERRUN, CHAN_OVERRUN} <= 14'h1 << i;
      rd(`ADCF_OFS_FLAGS);
      chk("ovr", 32'h1000 << i, d & 32'h03fff000);
    end
    // Mirrors set, reserved bits written as zero
    wr(`ADCF_OFS_FLAGS, 32'h03fff000);
    rd(`ADCF_OFS_FLAGS);
    chk("ovr_ro", 32'h02000000, d & 32'h03fff000);
    // Overrun enable path, sequence B mirror still high
    wr(`ADCF_OFS_IRQ_EN, 32'h8);
    chk("ovr_irq", 32'h1, IRQ);
    @(posedge CLOCK);
    {SEQ_B_OVERRUN, SEQ_A_OVERRUN, CHAN_OVERRUN} <= 14'h0;
    repeat (2) @(posedge CLOCK);
    #1;
    chk("ovr_irq_off", 32'h0, IRQ);
  endtask

  task t_mode0;
    wr(`ADCF_OFS_IRQ_EN, 32'h1);
    pulse(0);
    chk("dma0", 32'h1, SEQ_A_DMA_REQ);
    chk("irq0", 32'h1, IRQ);
    wr(`ADCF_OFS_FLAGS, 32'h10000000);
    chk("bresp_ok", `ADCF_RESP_OKAY, r);
    rd(`ADCF_OFS_FLAGS);
    chk("flag0", 32'h1, d[28]);
    rd(`ADCF_OFS_SEQA_GRES);
    chk("gres", 32'h8000a5c0, d);
    chk("dma0_rd", 32'h0, SEQ_A_DMA_REQ);
    chk("irq0_rd", 32'h0, IRQ);
    wr(`ADCF_OFS_IRQ_EN, 32'h0);
    pulse(0);
    chk("irq0_off", 32'h0, IRQ);
    rd(`ADCF_OFS_SEQA_GRES);
  endtask

  task t_mode1;
    wr(`ADCF_OFS_SEQ_A_CONTROL_REG, 32'h40000000);
    chk("mode", 32'h1, SEQ_A_MODE);
    wr(`ADCF_OFS_IRQ_EN, 32'h1);
    pulse(0);
    chk("dma1_conv", 32'h0, SEQ_A_DMA_REQ);
    pulse(1);
    chk("dma1_seq", 32'h1, SEQ_A_DMA_REQ);
    chk("irq1", 32'h1, IRQ);
    rd(`ADCF_OFS_SEQA_GRES);
    wr(`ADCF_OFS_FLAGS, 32'h0);
    chk("dma1_hold", 32'h1, SEQ_A_DMA_REQ);
    wr(`ADCF_OFS_FLAGS, 32'h10000000);
    chk("dma1_clr", 32'h0, SEQ_A_DMA_REQ);
    chk("irq1_clr", 32'h0, IRQ);
    wr(`ADCF_OFS_SEQ_A_CONTROL_REG, 32'h0);
  endtask

  task t_unmapped;
    rd(12'h0f0);
    chk("rresp", `ADCF_RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    wr(12'h0f0, 32'hffffffff);
    chk("bresp", `ADCF_RESP_SLVERR, r);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, CHAN_OVERRUN, S_AXI_WDATA} = 68'h0;
    {CONV_DONE_A, SEQ_A_DONE, THR_OUTSIDE_CH11, THR_CROSS_CH11} = 4'h0;
    {SEQ_A_OVERRUN, SEQ_B_OVERRUN, THR_FLAGS_LOW} = 13'h0;
    SEQ_A_RESULT = 12'ha5c;
    S_AXI_WSTRB = 4'hf;
    SRST = 1'h1;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge CLOCK);
    SRST <= 1'h0;
    t_reset;
    t_thr;
    t_ovr;
    t_mode0;
    t_mode1;
    t_unmapped;
    complete_run;
  end
endmodule

bind adcf_flags adcf_flags_chk chk_u (
  .CLOCK(CLOCK), .SRST(SRST),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .CONV_DONE_A(CONV_DONE_A), .SEQ_A_DONE(SEQ_A_DONE),
  .THR_FLAGS_LOW(THR_FLAGS_LOW), .CHAN_OVERRUN(CHAN_OVERRUN),
  .SEQ_A_OVERRUN(SEQ_A_OVERRUN), .SEQ_B_OVERRUN(SEQ_B_OVERRUN),
  .SEQ_A_MODE(SEQ_A_MODE), .SEQ_A_DMA_REQ(SEQ_A_DMA_REQ),
  .THRESHOLD_SUMMARY(THRESHOLD_SUMMARY), .IRQ(IRQ)
);
`default_nettype wire
